// [shared/sram_port_pkg.sv]
package sram_port_pkg;

  // ----------------------------------------
  // memory geometry
  // ----------------------------------------
  localparam int BYTE_W = 9;
  localparam int LANES_DEF = 4;
  localparam int ADDR_W_DEF = 18;
  localparam int BURST_LEN = 4;
  localparam int BURST_W = 2;

  // ----------------------------------------
  // register map (byte offsets in haddr[7:0])
  // ----------------------------------------
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] CTRL_OFF = 8'h00;
  localparam logic [REG_AW-1:0] STATUS_OFF = 8'h04;
  localparam logic [REG_AW-1:0] RD_COUNT_OFF = 8'h08;
  localparam logic [REG_AW-1:0] WR_COUNT_OFF = 8'h0C;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int CTRL_PORT_EN_BIT = 0;
  localparam int CTRL_CNT_CLR_BIT = 1;
  localparam logic CTRL_PORT_EN_RST = 1'b1;
  localparam int STAT_ASLEEP_BIT = 0;
  localparam int STAT_PIPE_BIT = 1;
  localparam int STAT_INTLV_BIT = 2;
  localparam int STAT_BURST_BIT = 3;
  localparam int STAT_LOW_LSB = 4;
  localparam int STAT_WBUF_BIT = 6;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ----------------------------------------
  // ahb encodings
  // ----------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

// [rtl/lane_buffer.sv]
`timescale 1ns/1ps
module lane_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] store_q [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  // ----------------------------------------
  // pointers
  // ----------------------------------------
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      wp_d = (wp_q == LAST) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == LAST) ? '0 : rp_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      store_q[wp_q] <= in_data;
    end
  end

  assign in_ready = (cnt_q != FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data = store_q[rp_q];
endmodule // lane_buffer

// [rtl/sync_sram_port.sv]
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module sync_sram_port
  import sram_port_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES = LANES_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:BURST_W] addr_hi,
  input wire logic burst_start_bit0,
  input wire logic burst_start_bit1,
  input wire logic write_n,
  input wire logic clk_gate_n,
  input wire logic burst_step_en,
  input wire logic chip_sel_a_n,
  input wire logic chip_sel_b,
  input wire logic chip_sel_c_n,
  input wire logic [LANES-1:0] lane_write_n,
  input wire logic burst_order_sel,
  input wire logic pipe_mode_sel,
  input wire logic sleep_request,
  input wire logic out_en_n,
  input wire logic [LANES*BYTE_W-1:0] dq_in,
  output logic [LANES*BYTE_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);
  localparam int DW = LANES * BYTE_W;
  localparam int BW = ADDR_W + LANES + DW;
  localparam int NSYNC = 4;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [BURST_W-1:0] burst_bits(input logic [BURST_W-1:0] start,
                                                     input logic [BURST_W-1:0] beat,
                                                     input logic interleave);
    // linear wraps naturally at two bits, which is modulo four
    burst_bits = interleave ? (start ^ beat) : BURST_W'(start + beat);
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [NSYNC-1:0] async_in, sync1_q, sync2_q;
  logic asleep, oe_off, pipe_mode, interleave;

  assign async_in = {pipe_mode_sel, burst_order_sel, out_en_n, sleep_request};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  assign asleep = sync2_q[0];
  assign oe_off = sync2_q[1];
  assign interleave = sync2_q[2];
  assign pipe_mode = sync2_q[3];

  // ----------------------------------------
  // storage and write buffer
  // ----------------------------------------
  logic [DW-1:0] mem [2**ADDR_W];
  logic wb_in_valid, wb_in_ready, wb_out_valid, wb_out_ready;
  logic [BW-1:0] wb_in_data, wb_out_data;
  logic [ADDR_W-1:0] wb_addr;
  logic [LANES-1:0] wb_lanes_n;
  logic [DW-1:0] wb_data;

  lane_buffer #(
    .WIDTH(BW),
    .DEPTH(2)
  ) u_wbuf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(wb_in_valid),
    .in_ready(wb_in_ready),
    .in_data(wb_in_data),
    .out_valid(wb_out_valid),
    .out_ready(wb_out_ready),
    .out_data(wb_out_data)
  );

  // the array stands still while asleep, so late writes wait in the buffer
  assign wb_out_ready = !asleep;
  assign {wb_addr, wb_lanes_n, wb_data} = wb_out_data;

  always_ff @(posedge clk_sys) begin
    for (int g = 0; g < LANES; g++) begin
      if (wb_out_valid && wb_out_ready && !wb_lanes_n[g]) begin
        mem[wb_addr][g*BYTE_W +: BYTE_W] <= wb_data[g*BYTE_W +: BYTE_W];
      end
    end
  end

  // ----------------------------------------
  // access pipeline
  // ----------------------------------------
  logic port_en_q;
  logic edge_en, sel_all, new_acc, step_acc;
  logic burst_act_q, burst_act_d, wr_b_q, wr_b_d;
  logic [ADDR_W-1:BURST_W] base_q, base_d;
  logic [BURST_W-1:0] start_q, start_d, beat_q, beat_d, low_now;
  logic v1_q, v1_d, wr1_q, wr1_d, v2_q, v2_d, wr2_q, wr2_d;
  logic [ADDR_W-1:0] addr1_q, addr1_d, addr2_q, addr2_d;
  logic [LANES-1:0] lanes1_q, lanes1_d, lanes2_q, lanes2_d;
  logic [DW-1:0] rd2_q, rd2_d, dq_out_q, dq_out_d;
  logic drive_q, drive_d, dq_oe_q, dq_oe_d;
  logic [31:0] rd_cnt_q, rd_cnt_d, wr_cnt_q, wr_cnt_d;
  logic cnt_clr;

  always_comb begin
    // edge sampling; a full write buffer also holds the edge back
    edge_en = !clk_gate_n && !asleep && wb_in_ready;
    sel_all = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n && port_en_q;
    new_acc = edge_en && !burst_step_en && sel_all;
    step_acc = edge_en && burst_step_en && burst_act_q;
    burst_act_d = burst_act_q;
    wr_b_d = wr_b_q;
    base_d = base_q;
    start_d = start_q;
    beat_d = beat_q;
    low_now = burst_bits(start_q, beat_q, interleave);
    if (new_acc) begin
      start_d = {burst_start_bit1, burst_start_bit0};
      base_d = addr_hi;
      beat_d = '0;
      wr_b_d = !write_n;
      burst_act_d = 1'b1;
      low_now = {burst_start_bit1, burst_start_bit0};
    end else if (step_acc) begin
      beat_d = beat_q + 1'b1;
      low_now = burst_bits(start_q, beat_q + 1'b1, interleave);
    end else if (edge_en && !burst_step_en) begin
      burst_act_d = 1'b0;
    end
  end

  always_comb begin
    v1_d = v1_q;
    wr1_d = wr1_q;
    addr1_d = addr1_q;
    lanes1_d = lanes1_q;
    v2_d = v2_q;
    wr2_d = wr2_q;
    addr2_d = addr2_q;
    lanes2_d = lanes2_q;
    rd2_d = rd2_q;
    dq_out_d = dq_out_q;
    drive_d = drive_q;
    wb_in_valid = 1'b0;
    wb_in_data = {addr1_q, lanes1_q, dq_in};
    rd_cnt_d = rd_cnt_q;
    wr_cnt_d = wr_cnt_q;
    if (edge_en) begin
      v1_d = new_acc || step_acc;
      wr1_d = new_acc ? !write_n : wr_b_q;
      addr1_d = {new_acc ? addr_hi : base_q, low_now};
      lanes1_d = lane_write_n;
      v2_d = v1_q;
      wr2_d = wr1_q;
      addr2_d = addr1_q;
      lanes2_d = lanes1_q;
      rd2_d = mem[addr1_q];
      if (pipe_mode) begin
        wb_in_valid = v2_q && wr2_q;
        wb_in_data = {addr2_q, lanes2_q, dq_in};
        dq_out_d = rd2_q;
        drive_d = v2_q && !wr2_q;
      end else begin
        wb_in_valid = v1_q && wr1_q;
        dq_out_d = mem[addr1_q];
        drive_d = v1_q && !wr1_q;
      end
      if (v1_d && !wr1_d) begin
        rd_cnt_d = rd_cnt_q + 32'h0000_0001;
      end
      if (v1_d && wr1_d) begin
        wr_cnt_d = wr_cnt_q + 32'h0000_0001;
      end
    end
    if (cnt_clr) begin
      rd_cnt_d = COUNT_RST;
      wr_cnt_d = COUNT_RST;
    end
    dq_oe_d = drive_d && !oe_off && !asleep;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      burst_act_q <= 1'b0;
      wr_b_q <= 1'b0;
      base_q <= '0;
      start_q <= '0;
      beat_q <= '0;
      v1_q <= 1'b0;
      wr1_q <= 1'b0;
      addr1_q <= '0;
      lanes1_q <= '1;
      v2_q <= 1'b0;
      wr2_q <= 1'b0;
      addr2_q <= '0;
      lanes2_q <= '1;
      rd2_q <= '0;
      dq_out_q <= '0;
      drive_q <= 1'b0;
      dq_oe_q <= 1'b0;
      rd_cnt_q <= COUNT_RST;
      wr_cnt_q <= COUNT_RST;
    end else begin
      burst_act_q <= burst_act_d;
      wr_b_q <= wr_b_d;
      base_q <= base_d;
      start_q <= start_d;
      beat_q <= beat_d;
      v1_q <= v1_d;
      wr1_q <= wr1_d;
      addr1_q <= addr1_d;
      lanes1_q <= lanes1_d;
      v2_q <= v2_d;
      wr2_q <= wr2_d;
      addr2_q <= addr2_d;
      lanes2_q <= lanes2_d;
      rd2_q <= rd2_d;
      dq_out_q <= dq_out_d;
      drive_q <= drive_d;
      dq_oe_q <= dq_oe_d;
      rd_cnt_q <= rd_cnt_d;
      wr_cnt_q <= wr_cnt_d;
    end
  end

  assign dq_out = dq_out_q;
  assign dq_oe = dq_oe_q;

  // ----------------------------------------
  // ahb-lite register slave
  // ----------------------------------------
  logic ph_wr_q, ph_wr_d, port_en_d;
  logic [REG_AW-1:0] ph_addr_q, ph_addr_d;
  logic [31:0] hrdata_q, hrdata_d, status;
  logic take;

  always_comb begin
    status = '0;
    status[STAT_ASLEEP_BIT] = asleep;
    status[STAT_PIPE_BIT] = pipe_mode;
    status[STAT_INTLV_BIT] = interleave;
    status[STAT_BURST_BIT] = burst_act_q;
    status[STAT_LOW_LSB +: BURST_W] = burst_bits(start_q, beat_q, interleave);
    status[STAT_WBUF_BIT] = wb_out_valid;
    take = hsel && (htrans == HTRANS_NONSEQ) && hready;
    ph_wr_d = take && hwrite;
    ph_addr_d = take ? haddr[REG_AW-1:0] : ph_addr_q;
    hrdata_d = hrdata_q;
    if (take && !hwrite) begin
      unique case (haddr[REG_AW-1:0])
        CTRL_OFF: hrdata_d = {31'h0000_0000, port_en_q};
        STATUS_OFF: hrdata_d = status;
        RD_COUNT_OFF: hrdata_d = rd_cnt_q;
        WR_COUNT_OFF: hrdata_d = wr_cnt_q;
        default: hrdata_d = RDATA_RST;
      endcase
    end
    port_en_d = port_en_q;
    cnt_clr = 1'b0;
    if (ph_wr_q && ph_addr_q == CTRL_OFF) begin
      port_en_d = hwdata[CTRL_PORT_EN_BIT];
      cnt_clr = hwdata[CTRL_CNT_CLR_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ph_wr_q <= 1'b0;
      ph_addr_q <= '0;
      hrdata_q <= RDATA_RST;
      port_en_q <= CTRL_PORT_EN_RST;
    end else begin
      ph_wr_q <= ph_wr_d;
      ph_addr_q <= ph_addr_d;
      hrdata_q <= hrdata_d;
      port_en_q <= port_en_d;
    end
  end

  // zero-wait slave: every transfer completes in its first data-phase cycle
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_q;
endmodule // sync_sram_port

// [tb/mem_ctl_model.sv]
`timescale 1ns/1ps
module mem_ctl_model
  import sram_port_pkg::*;
(
  input wire logic clk_sys,
  input wire logic pipe_mode_sel,
  output logic [ADDR_W_DEF-1:BURST_W] addr_hi,
  output logic burst_start_bit0,
  output logic burst_start_bit1,
  output logic write_n,
  output logic clk_gate_n,
  output logic burst_step_en,
  output logic chip_sel_a_n,
  output logic chip_sel_b,
  output logic chip_sel_c_n,
  output logic [LANES_DEF-1:0] lane_write_n,
  output logic [LANES_DEF*BYTE_W-1:0] dq_in,
  input wire logic [LANES_DEF*BYTE_W-1:0] dq_out,
  input wire logic dq_oe
);
  // ----------------------------------------
  // controller side of the memory port
  // ----------------------------------------
  initial begin
    {clk_gate_n, chip_sel_a_n, chip_sel_b, chip_sel_c_n} = 4'h5;
    {addr_hi, burst_start_bit1, burst_start_bit0, write_n, burst_step_en, lane_write_n, dq_in} = '0;
  end

  // sel packs {clk_gate_n, chip_sel_a_n, chip_sel_b, chip_sel_c_n}
  task automatic xfer(input logic w, input logic [15:0] a, input logic [1:0] s, input logic [3:0] ln,
                      input logic [35:0] d, input int n, input logic [3:0] sel,
                      output logic [35:0] q[4], output logic [3:0] oe);
    int lat;
    lat = pipe_mode_sel ? 2 : 1;
    @(posedge clk_sys);
    {clk_gate_n, chip_sel_a_n, chip_sel_b, chip_sel_c_n} <= sel;
    {addr_hi, burst_start_bit1, burst_start_bit0, write_n, lane_write_n} <= {a, s, w, ln};
    for (int i = 0; i < n + lat; i++) begin
      @(posedge clk_sys);
      burst_step_en <= (i + 1 < n);
      if (i + 1 >= n)
        {clk_gate_n, chip_sel_a_n, chip_sel_b, chip_sel_c_n} <= 4'h5;
      if (!w && i == lat - 1)
        dq_in <= d;
      // released bus shows the inverse so stale data cannot pass
      if (!w && i == lat)
        dq_in <= ~d;
      #1;
      if (i >= lat)
        {q[i-lat], oe[i-lat]} = {dq_out, dq_oe};
    end
  endtask
endmodule // mem_ctl_model

// [tb/sync_sram_port_asserts.sv]
`timescale 1ns/1ps
module sync_sram_port_asserts
  import sram_port_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES = LANES_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic write_n,
  input wire logic clk_gate_n,
  input wire logic burst_step_en,
  input wire logic chip_sel_a_n,
  input wire logic chip_sel_b,
  input wire logic chip_sel_c_n,
  input wire logic pipe_mode_sel,
  input wire logic sleep_request,
  input wire logic out_en_n,
  input wire logic [LANES*BYTE_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp
);
  // ----------------------------------------
  // helpers and sequences
  // ----------------------------------------
  logic quiet;
  logic rd_cmd;
  logic ctl_wr_q, port_on_q;
  // a read command only counts while software has the port switched on
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctl_wr_q <= 1'b0;
      port_on_q <= CTRL_PORT_EN_RST;
    end else begin
      ctl_wr_q <= hsel && (htrans == HTRANS_NONSEQ) && hready && hwrite && (haddr[REG_AW-1:0] == CTRL_OFF);
      if (ctl_wr_q) begin
        port_on_q <= hwdata[CTRL_PORT_EN_BIT];
      end
    end
  end
  assign quiet = !out_en_n && !sleep_request;
  assign rd_cmd = !clk_gate_n && !burst_step_en && !chip_sel_a_n && chip_sel_b && !chip_sel_c_n && write_n && port_on_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // four quiet edges let the synchronisers settle before a command counts
  sequence flow_rd_s;
    (quiet && !pipe_mode_sel) [*4] ##0 rd_cmd;
  endsequence
  sequence pipe_rd_s;
    (quiet && pipe_mode_sel) [*4] ##0 rd_cmd ##1 (quiet && !clk_gate_n);
  endsequence
  sequence go_s;
    quiet && !clk_gate_n;
  endsequence
  sequence idle_s;
    (!clk_gate_n && !burst_step_en && (chip_sel_a_n || !chip_sel_b || chip_sel_c_n)) [*3];
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  oe_off_a: assert property (out_en_n [*3] |=> !dq_oe)
    else $error("dq_oe high with output enable off");
  sleep_off_a: assert property (sleep_request [*3] |=> !dq_oe)
    else $error("dq_oe high while asleep");
  flow_lat_a: assert property (flow_rd_s ##1 go_s |=> dq_oe)
    else $error("flow-through read not driven after one edge");
  pipe_lat_a: assert property (pipe_rd_s ##1 go_s |=> dq_oe)
    else $error("pipelined read not driven after two edges");
  burst_step_a: assert property (flow_rd_s ##1 (go_s and burst_step_en) ##1 go_s |=> dq_oe)
    else $error("burst beat not driven");
  desel_quiet_a: assert property (idle_s |=> !dq_oe)
    else $error("dq_oe high while deselected");
  gate_hold_a: assert property (quiet [*4] ##0 clk_gate_n |=> $stable(dq_out) && $stable(dq_oe))
    else $error("outputs moved on a gated edge");
  ahb_okay_a: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("bus response not ready and okay");
endmodule // sync_sram_port_asserts

bind sync_sram_port sync_sram_port_asserts #(.ADDR_W(ADDR_W), .LANES(LANES)) u_chk (.*);

// [tb/sync_sram_port_tb.sv]
`timescale 1ns/1ps
module sync_sram_port_tb;
  import sram_port_pkg::*;
  // ----------------------------------------
  // bench signals
  // ----------------------------------------
  typedef struct {logic [3:0] ln; logic [8:0] b;} row_t;
  localparam logic [3:0] SEL_ON = 4'h2;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic burst_order_sel = 1'b0;
  logic pipe_mode_sel = 1'b0;
  logic sleep_request = 1'b0;
  logic out_en_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready, burst_start_bit0, burst_start_bit1, write_n, clk_gate_n, burst_step_en;
  logic chip_sel_a_n, chip_sel_b, chip_sel_c_n, dq_oe, hreadyout, hresp;
  logic [15:0] addr_hi;
  logic [3:0] lane_write_n, oe;
  logic [35:0] dq_in, dq_out;
  logic [35:0] q[4];
  logic [31:0] hrdata, rd;
  logic [1:0] bt;
  int n_errors = 0;
  int n_tests = 0;
  logic [3:0] offs[4] = '{4'h6, 4'h0, 4'h3, 4'ha};
  row_t rows[4] = '{'{4'h0, 9'h1a5}, '{4'he, 9'h0f3}, '{4'h7, 9'h15a}, '{4'h5, 9'h0cc}};

  assign hready = hreadyout;
  sync_sram_port u_dut (.*);
  mem_ctl_model u_ctl (.*);
  always #50 clk_sys = ~clk_sys;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] s);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk_sys);
    {hsel, htrans, haddr, hwrite} <= {1'b1, HTRANS_NONSEQ, 24'h00_0000, a, w};
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    r = hrdata;
  endtask

  function automatic logic [35:0] merge(input logic [3:0] ln, input logic [8:0] b);
    for (int l = 0; l < 4; l++) merge[l*9 +: 9] = ln[l] ? 9'h000 : b;
  endfunction

  task automatic stop_test();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ahb(1'b0, CTRL_OFF, 32'h0000_0000, rd);
    chk("ctrl_rst", 36'h0_0000_0001, 36'(rd));
    ahb(1'b0, 8'h40, 32'h0000_0000, rd);
    chk("unmapped", 36'h0_0000_0000, 36'(rd));
    foreach (rows[r]) begin
      u_ctl.xfer(1'b0, 16'h0010, 2'b01, 4'h0, 36'h0_0000_0000, 1, SEL_ON, q, oe);
      u_ctl.xfer(1'b0, 16'h0010, 2'b01, rows[r].ln, {4{rows[r].b}}, 1, SEL_ON, q, oe);
      repeat (4) @(posedge clk_sys);
      u_ctl.xfer(1'b1, 16'h0010, 2'b01, 4'hf, 36'h0_0000_0000, 1, SEL_ON, q, oe);
      chk("lane_write", merge(rows[r].ln, rows[r].b), q[0]);
    end
    // straps only move under reset, as a board would hold them
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys);
      {pipe_mode_sel, burst_order_sel} <= 2'(m);
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      for (int k = 0; k < 4; k++)
        u_ctl.xfer(1'b0, 16'h0020, 2'(k), 4'h0, {4{9'(k) + 9'h0a0}}, 1, SEL_ON, q, oe);
      repeat (4) @(posedge clk_sys);
      u_ctl.xfer(1'b1, 16'h0020, 2'b10, 4'hf, 36'h0_0000_0000, 4, SEL_ON, q, oe);
      for (int k = 0; k < 4; k++) begin
        bt = burst_order_sel ? 2'b10 ^ 2'(k) : 2'b10 + 2'(k);
        chk("burst_beat", {4{9'(bt) + 9'h0a0}}, q[k]);
        chk("beat_drive", 36'h0_0000_0001, 36'(oe[k]));
      end
    end
    foreach (offs[i]) begin
      u_ctl.xfer(1'b1, 16'h0020, 2'b00, 4'hf, 36'h0_0000_0000, 1, offs[i], q, oe);
      chk("refused_oe", 36'h0_0000_0000, 36'(oe[0]));
    end
    // counters cleared, then one write and a four-beat read
    ahb(1'b1, CTRL_OFF, 32'h0000_0003, rd);
    u_ctl.xfer(1'b0, 16'h0030, 2'b00, 4'h0, 36'h0_0000_0000, 1, SEL_ON, q, oe);
    u_ctl.xfer(1'b1, 16'h0030, 2'b00, 4'hf, 36'h0_0000_0000, 4, SEL_ON, q, oe);
    chk("late_write", 36'h0_0000_0000, q[0]);
    // port switched off: the command is refused and not counted
    ahb(1'b1, CTRL_OFF, 32'h0000_0000, rd);
    u_ctl.xfer(1'b1, 16'h0030, 2'b00, 4'hf, 36'h0_0000_0000, 1, SEL_ON, q, oe);
    chk("port_off_oe", 36'h0_0000_0000, 36'(oe[0]));
    ahb(1'b0, CTRL_OFF, 32'h0000_0000, rd);
    chk("ctrl_off", 36'h0_0000_0000, 36'(rd));
    ahb(1'b0, RD_COUNT_OFF, 32'h0000_0000, rd);
    chk("rd_count", 36'h0_0000_0004, 36'(rd));
    ahb(1'b0, WR_COUNT_OFF, 32'h0000_0000, rd);
    chk("wr_count", 36'h0_0000_0001, 36'(rd));
    ahb(1'b1, CTRL_OFF, 32'h0000_0001, rd);
    @(posedge clk_sys);
    out_en_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    u_ctl.xfer(1'b1, 16'h0020, 2'b01, 4'hf, 36'h0_0000_0000, 1, SEL_ON, q, oe);
    chk("oe_override", 36'h0_0000_0000, 36'(oe[0]));
    @(posedge clk_sys);
    out_en_n <= 1'b0;
    sleep_request <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ahb(1'b0, STATUS_OFF, 32'h0000_0000, rd);
    chk("asleep", 36'h0_0000_0001, 36'(rd[STAT_ASLEEP_BIT]));
    chk("stat_pipe", 36'(pipe_mode_sel), 36'(rd[STAT_PIPE_BIT]));
    chk("stat_order", 36'(burst_order_sel), 36'(rd[STAT_INTLV_BIT]));
    u_ctl.xfer(1'b1, 16'h0020, 2'b01, 4'hf, 36'h0_0000_0000, 1, SEL_ON, q, oe);
    chk("sleep_oe", 36'h0_0000_0000, 36'(oe[0]));
    sleep_request <= 1'b0;
    stop_test();
  end
endmodule // sync_sram_port_tb
